// ---- hdl/csd_decode.sv ----
// Purpose: decode and cycle timing for far stores, conditional stores,
//          subtract, flag-only and, trap, wait and swap forms
// Assumes: software writes one instruction descriptor at a time
// Notes:   busy_o stands for exactly the instruction's cycle count
//
// Overview of operation
// - width bit, 0 byte, 1 word
// - four-bit general operand field decode
// - three-bit short destination field decode
// - far dsp20 store, 5-7 bytes, 3/4 cycles
// - far pair store, 2-4 bytes, 3/4 cycles
// - store-if-nonzero 1/2 cycles, +1 when flag 0
// - store-if-zero 1/2 cycles, +1 when flag 1
// - select-store 3-5 bytes, 2/3 cycles
// - short subtract immediate, 1/3 cycles
// - general subtract immediate, 2/4 cycles
// - word width adds one immediate byte
// - register/memory subtract 2, 3 or 4 cycles
// - short accumulator-byte subtract, 2/3 cycles
// - immediate and-flags 2/4 cycles, 3-6 bytes
// - register/memory and-flags 2, 3 or 4 cycles
// - trap opcode one byte, 20 cycles
// - wait two bytes, 3 cycles, then waiting
// - swap, fixed data-register source, 4/5 cycles

`timescale 1ns/1ps

module csd_decode
  import csd_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // execution status
  output logic             busy_o,
  output logic             done_o,
  output logic             trap_o,
  output logic             waiting_o
);

  // ==========================================================
  // declarations
  csd_cmd_t   cmd_reg;
  csd_dec_t   dec;
  csd_dec_t   dec_reg;
  csd_stat_t  stat;
  csd_stat_t  stat_wr;
  csd_state_e state_reg;
  csd_op_e    op_reg;
  logic [4:0] cnt_reg;
  logic       go_reg;
  logic       done_sticky_reg;
  logic       wr_fire;
  logic       req_new;
  logic       cmd_ok;
  logic       launch;
  logic       finish;
  logic       z_hit;
  logic [2:0] dst3;
  logic [1:0] src2;

  assign dst3    = cmd_reg.dst[2:0];
  assign src2    = cmd_reg.src[1:0];
  assign stat_wr = wb_dat_i;
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign req_new = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign cmd_ok  = (state_reg == ST_IDLE) && !go_reg;
  assign launch  = go_reg && (state_reg == ST_IDLE) && !dec.bad;
  assign finish  = (state_reg == ST_RUN) && (cnt_reg == CNT_LAST);
  assign z_hit   = (cmd_reg.op == OP_STORE_IF_NONZERO) ?
                   !cmd_reg.zf : cmd_reg.zf;

  // ==========================================================
  // wishbone answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req_new;
    end
  end

  always_comb begin
    stat         = '0;
    stat.busy    = busy_o;
    stat.done    = done_sticky_reg;
    stat.waiting = waiting_o;
    stat.dec     = dec_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (req_new) begin
      unique case (wb_adr_i)
        CSD_OFS_CMD:  wb_dat_o <= {16'h0000, cmd_reg};
        CSD_OFS_STAT: wb_dat_o <= stat;
        default:      wb_dat_o <= '0;
      endcase
    end
  end

  // ==========================================================
  // command register, refused while an instruction runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg <= CSD_CMD_RST;
      go_reg  <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      if (wr_fire && (wb_adr_i == CSD_OFS_CMD) && cmd_ok) begin
        if (wb_sel_i[0]) begin
          cmd_reg[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          cmd_reg[15:8] <= wb_dat_i[15:8];
        end
        go_reg <= wb_sel_i[CSD_GO_LANE] && wb_dat_i[CSD_GO_BIT];
      end
    end
  end

  // ==========================================================
  // decode
  always_comb begin
    dec = '0;
    dec.skind = gen_kind(cmd_reg.src);
    dec.dkind = gen_kind(cmd_reg.dst);
    unique case (cmd_reg.op)
      OP_STORE_FAR_DSP: begin
        dec.bytes   = BYT_FAR_DSP + gen_ext(cmd_reg.src);
        dec.cycles  = gen_mem(cmd_reg.src) ? CYC_FAR_MEM : CYC_FAR_REG;
        dec.wr_dest = 1'b1;
      end
      OP_STORE_FAR_PAIR: begin
        dec.bytes   = BYT_FAR_PAIR + gen_ext(cmd_reg.src);
        dec.cycles  = gen_mem(cmd_reg.src) ? CYC_FAR_MEM : CYC_FAR_REG;
        dec.wr_dest = 1'b1;
      end
      OP_STORE_IF_NONZERO,
      OP_STORE_IF_EQUAL: begin
        dec.bytes   = BYT_STC + sd_ext(dst3);
        dec.cycles  = (sd_mem(dst3) ? CYC_STC_MEM : CYC_STC_REG)
                      + {4'h0, z_hit};
        dec.wr_dest = z_hit;
      end
      OP_STORE_SELECT: begin
        dec.bytes   = BYT_SEL + sd_ext(dst3);
        dec.cycles  = sd_mem(dst3) ? CYC_SEL_MEM : CYC_SEL_REG;
        dec.wr_dest = 1'b1;
      end
      OP_SUB_SHORT: begin
        dec.bytes     = BYT_SUBS + sd_ext(dst3);
        dec.cycles    = sd_mem(dst3) ? CYC_SUBS_MEM : CYC_SUBS_REG;
        dec.wr_dest   = 1'b1;
        dec.flags_upd = 1'b1;
      end
      OP_SUB_IMM,
      OP_AND_FLAGS_ONLY_IMM: begin
        dec.bytes     = BYT_IMM + gen_ext(cmd_reg.dst)
                        + {2'h0, cmd_reg.wide};
        dec.cycles    = gen_mem(cmd_reg.dst) ? CYC_IMM_MEM
                                             : CYC_IMM_REG;
        dec.wr_dest   = (cmd_reg.op == OP_SUB_IMM);
        dec.flags_upd = 1'b1;
      end
      OP_SUB_RM,
      OP_AND_FLAGS_ONLY_RM: begin
        dec.bytes     = BYT_RM + gen_ext(cmd_reg.src)
                        + gen_ext(cmd_reg.dst);
        dec.cycles    = CYC_RM_BASE + {4'h0, gen_mem(cmd_reg.src)}
                        + {4'h0, gen_mem(cmd_reg.dst)};
        dec.wr_dest   = (cmd_reg.op == OP_SUB_RM);
        dec.flags_upd = 1'b1;
      end
      OP_SUB_ACC: begin
        dec.dkind     = cmd_reg.dst[0] ? K_ACC0_HIGH_BYTE
                                       : K_ACC0_LOW_BYTE;
        if (src2 == SS_REG) begin
          dec.skind = cmd_reg.dst[0] ? K_ACC0_LOW_BYTE
                                     : K_ACC0_HIGH_BYTE;
        end else if (src2 == SS_ABS16) begin
          dec.skind = K_ABS16;
        end else begin
          dec.skind = K_DSP8;
        end
        dec.bytes     = BYT_ACC + ((src2 == SS_ABS16) ? EXT2 :
                        ((src2 == SS_REG) ? EXT0 : EXT1));
        dec.cycles    = (src2 == SS_REG) ? CYC_ACC_REG : CYC_ACC_MEM;
        dec.wr_dest   = 1'b1;
        dec.flags_upd = 1'b1;
      end
      OP_ILLEGAL_TRAP: begin
        dec.bytes  = BYT_TRAP;
        dec.cycles = CYC_TRAP;
      end
      OP_WAIT: begin
        dec.bytes  = BYT_WAIT;
        dec.cycles = CYC_WAIT;
      end
      OP_SWAP: begin
        dec.skind   = K_DATA_REG;
        dec.bytes   = BYT_SWAP + gen_ext(cmd_reg.dst);
        dec.cycles  = gen_mem(cmd_reg.dst) ? CYC_SWAP_MEM
                                           : CYC_SWAP_REG;
        dec.wr_dest = 1'b1;
      end
      default: begin
        dec.bad = 1'b1;
      end
    endcase
    if ((cmd_reg.op == OP_STORE_IF_NONZERO) ||
        (cmd_reg.op == OP_STORE_IF_EQUAL) ||
        (cmd_reg.op == OP_STORE_SELECT) ||
        (cmd_reg.op == OP_SUB_SHORT)) begin
      dec.bad   = dst3 < SD_ACC_HI;
      dec.dkind = (dst3 == SD_ACC_HI) ? K_ACC0_HIGH_BYTE :
                  (dst3 == SD_ACC_LO) ? K_ACC0_LOW_BYTE :
                  (dst3 == SD_ABS16) ? K_ABS16 : K_DSP8;
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      busy_o    <= 1'b0;
      op_reg    <= OP_STORE_FAR_DSP;
    end else if (launch) begin
      state_reg <= ST_RUN;
      cnt_reg   <= dec.cycles;
      busy_o    <= 1'b1;
      op_reg    <= cmd_reg.op;
    end else if (finish) begin
      state_reg <= ST_IDLE;
      busy_o    <= 1'b0;
    end else if (state_reg == ST_RUN) begin
      cnt_reg <= cnt_reg - CNT_LAST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_reg <= '0;
    end else if (go_reg && (state_reg == ST_IDLE)) begin
      dec_reg <= dec;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o    <= 1'b0;
      trap_o    <= 1'b0;
      waiting_o <= 1'b0;
    end else begin
      done_o <= finish;
      trap_o <= finish && (op_reg == OP_ILLEGAL_TRAP);
      if (finish && (op_reg == OP_WAIT)) begin
        waiting_o <= 1'b1;
      end else if (launch) begin
        waiting_o <= 1'b0;
      end
    end
  end

  // completion flag: a finish in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_sticky_reg <= 1'b0;
    end else if (finish) begin
      done_sticky_reg <= 1'b1;
    end else if (wr_fire && (wb_adr_i == CSD_OFS_STAT) &&
                 wb_sel_i[0] && stat_wr.done) begin
      done_sticky_reg <= 1'b0;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_FAR_DSP_REG:
  assert property (launch && (cmd_reg.op == OP_STORE_FAR_DSP) &&
    !gen_mem(cmd_reg.src) |-> ##1 busy_o [*3] ##1 (!busy_o && done_o))
  else $error("far store from register not 3 cycles");

  AST_FAR_PAIR_BYTES:
  assert property (launch && (cmd_reg.op == OP_STORE_FAR_PAIR) &&
    (cmd_reg.src >= GEN_DSP16) |=> dec_reg.bytes == 3'h4 &&
    dec_reg.cycles == 5'h04)
  else $error("pair far store size wrong");

  AST_NZ_EXTRA:
  assert property (launch && (cmd_reg.op == OP_STORE_IF_NONZERO) &&
    !cmd_reg.zf && !sd_mem(dst3) |-> ##1 busy_o [*2] ##1
    (done_o && dec_reg.wr_dest))
  else $error("store-if-nonzero timing wrong");

  AST_EQ_WRITE:
  assert property (launch && (cmd_reg.op == OP_STORE_IF_EQUAL) |=>
    dec_reg.wr_dest == $past(cmd_reg.zf))
  else $error("store-if-zero write decision wrong");

  AST_SEL_ABS:
  assert property (launch && (cmd_reg.op == OP_STORE_SELECT) &&
    (dst3 == SD_ABS16) |=> dec_reg.bytes == 3'h5 &&
    dec_reg.cycles == 5'h03)
  else $error("select store figures wrong");

  AST_SUBS_MEM:
  assert property (launch && (cmd_reg.op == OP_SUB_SHORT) &&
    sd_mem(dst3) |-> ##1 busy_o [*3] ##1 done_o)
  else $error("short subtract memory not 3 cycles");

  AST_IMM_WORD:
  assert property (launch && ((cmd_reg.op == OP_AND_FLAGS_ONLY_IMM) ||
    (cmd_reg.op == OP_SUB_IMM)) &&
    cmd_reg.wide && (cmd_reg.dst >= GEN_DSP16) |=>
    dec_reg.bytes == 3'h6)
  else $error("word immediate byte count wrong");

  AST_RM_BOTH_MEM:
  assert property (launch && (cmd_reg.op == OP_SUB_RM) &&
    gen_mem(cmd_reg.src) && gen_mem(cmd_reg.dst) |->
    ##1 busy_o [*4] ##1 (done_o && !busy_o))
  else $error("subtract memory to memory not 4 cycles");

  AST_TRAP_ENTRY:
  assert property (launch && (cmd_reg.op == OP_ILLEGAL_TRAP) |->
    ##20 busy_o ##1 (trap_o && !busy_o))
  else $error("trap entry not after 20 cycles");

  AST_WAIT_STATE:
  assert property (launch && (cmd_reg.op == OP_WAIT) |->
    ##1 busy_o [*3] ##1 (waiting_o && done_o))
  else $error("wait not entered after 3 cycles");

  AST_SWAP_MEM:
  assert property (launch && (cmd_reg.op == OP_SWAP) &&
    gen_mem(cmd_reg.dst) |-> ##1 busy_o [*5] ##1 done_o)
  else $error("swap to memory not 5 cycles");

  AST_AND_FLAGS:
  assert property (launch && (cmd_reg.op == OP_AND_FLAGS_ONLY_RM) |=>
    !dec_reg.wr_dest && dec_reg.flags_upd)
  else $error("flag-only and writes a result");

  AST_ACK_ONE:
  assert property (req_new |=> wb_ack_o ##1 !wb_ack_o)
  else $error("wishbone ack not a single cycle");

endmodule

// ---- pkg/csd_pkg.sv ----
// Purpose: shared types, field layouts and cycle figures of the decoder
// Assumes: one clock, registers reached over classic wishbone
// Notes:   cycle and byte figures are per instruction form

package csd_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] CSD_OFS_CMD  = 8'h00;
  localparam logic [7:0] CSD_OFS_STAT = 8'h04;
  localparam int         CSD_GO_BIT   = 16;
  localparam int         CSD_GO_LANE  = 2;
  localparam logic [15:0] CSD_CMD_RST = 16'h0000;

  // ==========================================================
  // operation codes written by software
  typedef enum logic [3:0] {
    OP_STORE_FAR_DSP      = 4'b0000,
    OP_STORE_FAR_PAIR     = 4'b0001,
    OP_STORE_IF_NONZERO   = 4'b0010,
    OP_STORE_IF_EQUAL     = 4'b0011,
    OP_STORE_SELECT       = 4'b0100,
    OP_SUB_IMM            = 4'b0101,
    OP_SUB_SHORT          = 4'b0110,
    OP_SUB_RM             = 4'b0111,
    OP_SUB_ACC            = 4'b1000,
    OP_AND_FLAGS_ONLY_IMM = 4'b1001,
    OP_AND_FLAGS_ONLY_RM  = 4'b1010,
    OP_ILLEGAL_TRAP       = 4'b1011,
    OP_WAIT               = 4'b1100,
    OP_SWAP               = 4'b1101
  } csd_op_e;

  // operand kinds reported back
  typedef enum logic [2:0] {
    K_DATA_REG       = 3'b000,
    K_ADDR_REG       = 3'b001,
    K_INDIRECT       = 3'b010,
    K_DSP8           = 3'b011,
    K_DSP16          = 3'b100,
    K_ABS16          = 3'b101,
    K_ACC0_HIGH_BYTE = 3'b110,
    K_ACC0_LOW_BYTE  = 3'b111
  } csd_kind_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } csd_state_e;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [3:0] dst;
    logic [3:0] src;
    logic [1:0] pad;
    logic       zf;
    logic       wide;
    csd_op_e    op;
  } csd_cmd_t;

  typedef struct packed {
    logic       bad;
    logic [2:0] bytes;
    logic [4:0] cycles;
    logic       wr_dest;
    logic       flags_upd;
    csd_kind_e  skind;
    csd_kind_e  dkind;
  } csd_dec_t;

  typedef struct packed {
    logic [8:0] pad_hi;
    csd_dec_t   dec;
    logic [2:0] pad_lo;
    logic       waiting;
    logic       done;
    logic       busy;
  } csd_stat_t;

  // ==========================================================
  // field codes
  localparam logic [3:0] GEN_AREG  = 4'h4;
  localparam logic [3:0] GEN_IND   = 4'h6;
  localparam logic [3:0] GEN_DSP8  = 4'h8;
  localparam logic [3:0] GEN_DSP16 = 4'hC;
  localparam logic [3:0] GEN_ABS16 = 4'hF;
  localparam logic [2:0] SD_ACC_HI = 3'h3;
  localparam logic [2:0] SD_ACC_LO = 3'h4;
  localparam logic [2:0] SD_DSP8   = 3'h5;
  localparam logic [2:0] SD_ABS16  = 3'h7;
  localparam logic [1:0] SS_REG    = 2'h0;
  localparam logic [1:0] SS_ABS16  = 2'h3;
  localparam logic [2:0] EXT0      = 3'h0;
  localparam logic [2:0] EXT1      = 3'h1;
  localparam logic [2:0] EXT2      = 3'h2;

  // ==========================================================
  // byte counts and cycle counts
  localparam logic [2:0] BYT_FAR_DSP  = 3'h5;
  localparam logic [2:0] BYT_FAR_PAIR = 3'h2;
  localparam logic [2:0] BYT_STC      = 3'h2;
  localparam logic [2:0] BYT_SEL      = 3'h3;
  localparam logic [2:0] BYT_SUBS     = 3'h2;
  localparam logic [2:0] BYT_IMM      = 3'h3;
  localparam logic [2:0] BYT_RM       = 3'h2;
  localparam logic [2:0] BYT_ACC      = 3'h1;
  localparam logic [2:0] BYT_TRAP     = 3'h1;
  localparam logic [2:0] BYT_WAIT     = 3'h2;
  localparam logic [2:0] BYT_SWAP     = 3'h2;
  localparam logic [4:0] CYC_FAR_REG  = 5'h03;
  localparam logic [4:0] CYC_FAR_MEM  = 5'h04;
  localparam logic [4:0] CYC_STC_REG  = 5'h01;
  localparam logic [4:0] CYC_STC_MEM  = 5'h02;
  localparam logic [4:0] CYC_SEL_REG  = 5'h02;
  localparam logic [4:0] CYC_SEL_MEM  = 5'h03;
  localparam logic [4:0] CYC_SUBS_REG = 5'h01;
  localparam logic [4:0] CYC_SUBS_MEM = 5'h03;
  localparam logic [4:0] CYC_IMM_REG  = 5'h02;
  localparam logic [4:0] CYC_IMM_MEM  = 5'h04;
  localparam logic [4:0] CYC_RM_BASE  = 5'h02;
  localparam logic [4:0] CYC_ACC_REG  = 5'h02;
  localparam logic [4:0] CYC_ACC_MEM  = 5'h03;
  localparam logic [4:0] CYC_TRAP     = 5'h14;
  localparam logic [4:0] CYC_WAIT     = 5'h03;
  localparam logic [4:0] CYC_SWAP_REG = 5'h04;
  localparam logic [4:0] CYC_SWAP_MEM = 5'h05;
  localparam logic [4:0] CNT_LAST     = 5'h01;

  // ==========================================================
  // field decoders
  function automatic csd_kind_e gen_kind(input logic [3:0] f);
    if (f == GEN_ABS16) return K_ABS16;
    if (f >= GEN_DSP16) return K_DSP16;
    if (f >= GEN_DSP8) return K_DSP8;
    if (f >= GEN_IND) return K_INDIRECT;
    if (f >= GEN_AREG) return K_ADDR_REG;
    return K_DATA_REG;
  endfunction

  function automatic logic gen_mem(input logic [3:0] f);
    return f >= GEN_IND;
  endfunction

  function automatic logic [2:0] gen_ext(input logic [3:0] f);
    return (f >= GEN_DSP16) ? EXT2 : ((f >= GEN_DSP8) ? EXT1 : EXT0);
  endfunction

  function automatic logic sd_mem(input logic [2:0] f);
    return f >= SD_DSP8;
  endfunction

  function automatic logic [2:0] sd_ext(input logic [2:0] f);
    return (f == SD_ABS16) ? EXT2 : (sd_mem(f) ? EXT1 : EXT0);
  endfunction

endpackage

// ---- testbench/csd_wb_master.sv ----
// Purpose: classic wishbone host standing for software on the bus
// Assumes: start pulses only after the previous access has finished
// Notes:   request held until ack is sampled; write data inverted on release
`timescale 1ns/1ps

module csd_wb_master (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // bench side
  input  wire logic        start_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic             done_o   = 1'b0,
  output logic      [31:0] rdat_o   = 32'h0000_0000,
  // wishbone side
  output logic             wb_cyc_o = 1'b0,
  output logic             wb_stb_o = 1'b0,
  output logic             wb_we_o  = 1'b0,
  output logic      [7:0]  wb_adr_o = 8'h00,
  output logic      [3:0]  wb_sel_o = 4'h0,
  output logic      [31:0] wb_dat_o = 32'h0000_0000,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i
);
  // ====================
  // one access per start pulse
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
    end else if (wb_cyc_o && wb_ack_i) begin
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_dat_o <= ~wb_dat_o;
      rdat_o   <= wb_dat_i;
      done_o   <= 1'b1;
    end else if (!wb_cyc_o && start_i) begin
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o  <= we_i;
      wb_adr_o <= adr_i;
      wb_sel_o <= sel_i;
      wb_dat_o <= dat_i;
    end
  end

endmodule

// ---- testbench/tb_cpu_store_sub_test_swap_op_decode.sv ----
// Purpose: self-checking bench for the decode and timing block
// Assumes: every register access goes through the wishbone host model
// Notes:   busy length, done, trap, waiting and status fields per row
`timescale 1ns/1ps

module tb_cpu_store_sub_test_swap_op_decode
  import csd_pkg::*;
;
  // ====================
  // clock, reset and wiring
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        start = 1'b0;
  logic        m_we  = 1'b0;
  logic [7:0]  m_adr = 8'h00;
  logic [3:0]  m_sel = 4'h0;
  logic [31:0] m_dat = 32'h0000_0000;
  logic        m_done;
  logic [31:0] m_rdat;
  logic        cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dwr, drd, q;
  logic        busy, done, trap, waiting;
  logic [29:0] r;
  logic        dn, tr;
  int          nb;
  int          n_errors = 0;
  int          n_tests  = 0;

  always #2.5 clk_i = ~clk_i;

  csd_decode i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr),
    .wb_dat_o(drd), .wb_ack_o(ack), .busy_o(busy), .done_o(done),
    .trap_o(trap), .waiting_o(waiting));

  csd_wb_master i_host (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start), .we_i(m_we),
    .adr_i(m_adr), .sel_i(m_sel), .dat_i(m_dat), .done_o(m_done),
    .rdat_o(m_rdat), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dwr), .wb_ack_i(ack),
    .wb_dat_i(drd));

  // forms and figures
  // cmd; cycles; bytes; dst kind; kind checked, writes dest, flags
  localparam logic [29:0] ROWS [24] = '{
    {16'h0000, 5'h03, 3'h5, 3'h0, 3'h2},
    {16'h0800, 5'h04, 3'h6, 3'h0, 3'h2},
    {16'h0401, 5'h03, 3'h2, 3'h0, 3'h2},
    {16'h0E01, 5'h04, 3'h4, 3'h0, 3'h2},
    {16'h3002, 5'h02, 3'h2, 3'h6, 3'h6},
    {16'h7022, 5'h02, 3'h4, 3'h5, 3'h4},
    {16'h4023, 5'h02, 3'h2, 3'h7, 3'h6},
    {16'h5003, 5'h02, 3'h3, 3'h3, 3'h4},
    {16'h4004, 5'h02, 3'h3, 3'h7, 3'h6},
    {16'h7004, 5'h03, 3'h5, 3'h5, 3'h6},
    {16'h0005, 5'h02, 3'h3, 3'h0, 3'h7},
    {16'hC015, 5'h04, 3'h6, 3'h4, 3'h7},
    {16'h3006, 5'h01, 3'h2, 3'h6, 3'h7},
    {16'h6006, 5'h03, 3'h3, 3'h3, 3'h7},
    {16'h2107, 5'h02, 3'h2, 3'h0, 3'h7},
    {16'h9F07, 5'h04, 3'h5, 3'h3, 3'h7},
    {16'h1008, 5'h02, 3'h1, 3'h6, 3'h7},
    {16'h0308, 5'h03, 3'h3, 3'h7, 3'h7},
    {16'h1009, 5'h02, 3'h3, 3'h0, 3'h5},
    {16'h7019, 5'h04, 3'h4, 3'h2, 3'h5},
    {16'hBA0A, 5'h04, 3'h4, 3'h3, 3'h5},
    {16'h000B, 5'h14, 3'h1, 3'h0, 3'h0},
    {16'h000C, 5'h03, 3'h2, 3'h0, 3'h0},
    {16'hF00D, 5'h05, 3'h4, 3'h5, 3'h6}
  };

  // ====================
  // compare, report and bus tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_b(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    start <= 1'b1;
    m_we  <= w;
    m_adr <= a;
    m_sel <= s;
    m_dat <= d;
    @(posedge clk_i);
    start <= 1'b0;
    for (int k = 0; k < 20 && m_done !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
    if (m_done !== 1'b1) begin
      n_errors++;
      $display("BAD bus_answer expected 1 seen %b", m_done);
      results();
    end
    q = m_rdat;
  endtask

  // busy cycles counted until the done pulse, bounded
  task automatic meas();
    nb = 0;
    dn = 1'b0;
    tr = 1'b0;
    for (int k = 0; k < 40 && !dn; k++) begin
      @(posedge clk_i);
      #1;
      if (busy === 1'b1)
        nb++;
      if (done === 1'b1) begin
        dn = 1'b1;
        tr = trap;
      end
    end
  endtask

  task automatic run(input logic [15:0] cmd);
    wb(1'b1, CSD_OFS_CMD, 4'h7, {15'h0000, 1'b1, cmd});
    meas();
  endtask

  // ====================
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CSD_OFS_STAT, 4'hF, 32'h0000_0000);
    chk("stat_reset", 32'h0000_0000, q);
    wb(1'b0, CSD_OFS_CMD, 4'hF, 32'h0000_0000);
    chk("cmd_reset", 32'(CSD_CMD_RST), q);
    for (int i = 0; i < 24; i++) begin
      r = ROWS[i];
      run(r[29:14]);
      chk("busy_len", 32'(r[13:9]), 32'(nb));
      chk_b("done_pulse", 1'b1, dn);
      chk_b("trap_pulse", r[17:14] == 4'hB, tr);
      chk_b("waiting", r[17:14] == 4'hC, waiting);
      wb(1'b0, CSD_OFS_STAT, 4'hF, 32'h0000_0000);
      chk("stat_cycles", 32'(r[13:9]), 32'(q[18:14]));
      chk("stat_bytes", 32'(r[8:6]), 32'(q[21:19]));
      if (r[2])
        chk("dst_kind", 32'(r[5:3]), 32'(q[8:6]));
      chk_b("writes_dest", r[1], q[13]);
      chk_b("flags_upd", r[0], q[12]);
      chk_b("bad_desc", 1'b0, q[22]);
    end
    // descriptor without go, unmapped place
    wb(1'b1, CSD_OFS_CMD, 4'h3, 32'h0000_9F07);
    wb(1'b1, 8'h08, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, 8'h08, 4'hF, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, q);
    wb(1'b0, CSD_OFS_CMD, 4'hF, 32'h0000_0000);
    chk("cmd_readback", 32'h0000_9F07, q);
    chk_b("no_launch", 1'b0, busy);
    // a launch during busy is ignored
    wb(1'b1, CSD_OFS_CMD, 4'h7, 32'h0001_000B);
    wb(1'b1, CSD_OFS_CMD, 4'h7, 32'h0001_1005);
    meas();
    chk_b("trap_end", 1'b1, tr);
    wb(1'b0, CSD_OFS_CMD, 4'hF, 32'h0000_0000);
    chk("cmd_kept", 32'h0000_000B, q);
    meas();
    chk_b("no_rerun", 1'b0, dn);
    // bad op does not run; done sticky then cleared by one
    run(16'h000E);
    chk_b("bad_no_done", 1'b0, dn);
    chk("bad_no_busy", 32'h0000_0000, 32'(nb));
    wb(1'b0, CSD_OFS_STAT, 4'hF, 32'h0000_0000);
    chk_b("bad_flag", 1'b1, q[22]);
    chk_b("done_sticky", 1'b1, q[1]);
    wb(1'b1, CSD_OFS_STAT, 4'hF, 32'h0000_0002);
    wb(1'b0, CSD_OFS_STAT, 4'hF, 32'h0000_0000);
    chk_b("done_clear", 1'b0, q[1]);
    // second reset in mid-run
    wb(1'b1, CSD_OFS_CMD, 4'h7, 32'h0001_000B);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk_b("busy_reset", 1'b0, busy);
    meas();
    chk_b("reset_no_done", 1'b0, dn);
    wb(1'b0, CSD_OFS_STAT, 4'hF, 32'h0000_0000);
    chk("stat_reset2", 32'h0000_0000, q);
    results();
  end

endmodule
